// ===== dv/a429r_assertions.sv
/*
  Checker of the receiver's ports: reset values, update timing and word qualification.
  Assumes it is bound to a429r_top with the same INVERT_OUT.
*/
`timescale 1ns/1ns
module a429r_assertions
#(
  parameter bit INVERT_OUT = 1'b0
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Line and filter pins.
  input wire logic line_input_pos,
  input wire logic line_input_neg,
  input wire logic rate_hi,
  input wire logic parity_enable,
  input wire logic selftest_word_show,
  input wire logic [7:0] label_match_value,
  input wire logic [7:0] label_compare_en,
  input wire logic srcdst_compare_enable,
  input wire logic srcdst_match_lo,
  input wire logic srcdst_match_hi,
  // Outputs under watch.
  input wire logic [31:0] word_out,
  input wire logic update
);
  logic [31:0] rx_word; // Output word with the inversion undone.
  logic [7:0] lbl_line; // Label value in line bit order.
  logic [7:0] en_line; // Compare enables in line bit order.
  logic line_null; // Neither or both levels driven on the line.
  assign rx_word = word_out ^ {32{INVERT_OUT}};
  assign lbl_line = {<<{label_match_value}};
  assign en_line = {<<{label_compare_en}};
  assign line_null = !(line_input_pos ^ line_input_neg);

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // A load is one low cycle of update followed by its return.
  sequence s_reload;
    !update ##1 update;
  endsequence

  chk_reset_clear: assert property (disable iff (1'b0)
    !resetn |-> rx_word == 32'h0 && !update) else $error("outputs not cleared in reset");
  chk_update_reload: assert property ($fell(update) |-> s_reload)
    else $error("update low for more than one cycle");
  chk_update_holds: assert property ($rose(update) |=> update[*8])
    else $error("update did not hold high");
  chk_word_on_rise: assert property (
    !selftest_word_show && !$stable(word_out) |-> $rose(update))
    else $error("word changed without update rising");
  chk_gap_close: assert property ($fell(update) |-> line_null &&
    $past(line_null, 8) && $past(line_null, 200) && (rate_hi || $past(line_null, 1000)))
    else $error("word closed without a full gap");
  chk_parity_odd: assert property ($rose(update) && parity_enable |-> ^rx_word)
    else $error("word with even parity accepted");
  chk_label_match: assert property (
    $rose(update) |-> ((rx_word[7:0] ^ lbl_line) & en_line) == 8'h0)
    else $error("word accepted with label mismatch");
  chk_srcdst_match: assert property ($rose(update) && srcdst_compare_enable |->
    rx_word[9:8] == {srcdst_match_hi, srcdst_match_lo}) else $error("srcdst mismatch");
endmodule

// ===== dv/a429r_line_tx.sv
/*
  Line partner: a free-running bit-timing clock and a return-to-zero word sender.
  Assumes a 20 MHz core_clk. The line rests null between bits and between words.
*/
`timescale 1ns/1ns
module a429r_line_tx
(
  // Core clock used as the time base.
  input wire logic core_clk,
  // Bit clock and line levels.
  output logic bit_timing_clock,
  output logic line_pos,
  output logic line_neg
);
  int div_cnt = 0; // Core cycles into the half period.

  // The line starts null and the bit clock starts low.
  initial
  begin
    bit_timing_clock = 1'b0;
    line_pos = 1'b0;
    line_neg = 1'b0;
  end

  // Ten core cycles per half period give a 1 MHz bit clock.
  always @(posedge core_clk)
  begin
    div_cnt <= (div_cnt == 9) ? 0 : div_cnt + 1;
    if (div_cnt == 9)
      bit_timing_clock <= ~bit_timing_clock;
  end

  // Sends nb bits, first bit first, then a two-cell null gap.
  task automatic send(input logic [31:0] w, input int nb, input int cyc);
    for (int i = 0; i < nb; i++)
    begin
      line_pos = w[i];
      line_neg = ~w[i];
      repeat (cyc / 2) @(posedge core_clk);
      #2 line_pos = 1'b0;
      line_neg = 1'b0;
      repeat (cyc / 2) @(posedge core_clk);
      #2;
    end
    repeat (cyc * 2) @(posedge core_clk);
    #2;
  endtask
endmodule

// ===== dv/tb.sv
/*
  Testbench: self-test, resets and word filtering at both line rates, in both
  output variants side by side.
  Assumes the package, the header, the partner model and the checker are compiled first.
*/
`timescale 1ns/1ns
`include "a429r_defs.svh"
`define CHK(nm, ex, gt) \
  begin \
    cmp_count++; \
    if ((gt) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("ERROR %s expected %h seen %h", nm, ex, gt); \
    end \
  end
module tb
  import a429r_pkg::*;
;
  localparam bit INV = 1'b0; // Output variant under test.
  localparam int HI_CYC = 200; // Core cycles per high-speed bit.
  localparam int LO_CYC = 1600; // Core cycles per low-speed bit.
  localparam int LIMIT = 100000; // Cycle ceiling for the run.
  logic core_clk, resetn, st_dis_n, st_show, btc, lp, ln, update, st_pass;
  logic update_inv, st_pass_inv; // Status of the complemented variant.
  logic [31:0] word_out, exp_w, w, r;
  logic [31:0] word_out_inv; // Word outputs of the complemented variant.
  logic [31:0] exp_q[$]; // Words expected on the outputs, oldest first.
  a429r_cfg_s cfg; // Filter and mode pins.
  int seed = 49483;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;

  a429r_line_tx ptx (.core_clk(core_clk), .bit_timing_clock(btc), .line_pos(lp),
    .line_neg(ln));
  a429r_top #(.INVERT_OUT(INV)) uut (.core_clk(core_clk), .resetn(resetn),
    .bit_timing_clock(btc), .line_input_pos(lp), .line_input_neg(ln),
    .rate_hi(cfg.rate_hi), .parity_enable(cfg.parity_en), .selftest_disable_n(st_dis_n),
    .selftest_word_show(st_show), .label_match_value(cfg.label_value),
    .label_compare_en(cfg.label_en), .srcdst_compare_enable(cfg.sd_en),
    .srcdst_match_lo(cfg.sd_match[0]), .srcdst_match_hi(cfg.sd_match[1]),
    .word_out(word_out), .update(update), .selftest_pass(st_pass));
  // The other output variant sees the same pins, so its word must be the complement.
  a429r_top #(.INVERT_OUT(!INV)) uut_inv (.core_clk(core_clk), .resetn(resetn),
    .bit_timing_clock(btc), .line_input_pos(lp), .line_input_neg(ln),
    .rate_hi(cfg.rate_hi), .parity_enable(cfg.parity_en), .selftest_disable_n(st_dis_n),
    .selftest_word_show(st_show), .label_match_value(cfg.label_value),
    .label_compare_en(cfg.label_en), .srcdst_compare_enable(cfg.sd_en),
    .srcdst_match_lo(cfg.sd_match[0]), .srcdst_match_hi(cfg.sd_match[1]),
    .word_out(word_out_inv), .update(update_inv), .selftest_pass(st_pass_inv));

  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  // Each rise of update takes the oldest expected word; none left means a stray load.
  always @(posedge update)
  begin
    #1;
    exp_w = exp_q.size() ? exp_q.pop_front() : ~word_out ^ {32{INV}};
    `CHK("word_out", exp_w ^ {32{INV}}, word_out)
    `CHK("word_out inv", exp_w ^ {32{!INV}}, word_out_inv)
    `CHK("update inv", 1'b1, update_inv)
  end

  // A hang counts as a mismatch and ends the run.
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  // Sets the top bit so the word has odd parity.
  function automatic logic [31:0] odd(input logic [30:0] b);
    return {~^b, b};
  endfunction

  task print_verdict;
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Notes the word if it should load, sends it, then checks nothing is left pending.
  task automatic run(input string nm, input logic [31:0] wd, input int nb, input bit ok);
    if (ok)
      exp_q.push_back(wd);
    ptx.send(wd, nb, cfg.rate_hi ? HI_CYC : LO_CYC);
    `CHK({nm, " backlog"}, 0, exp_q.size())
    $display("test %s done", nm);
  endtask

  initial
  begin
    resetn = 1'b1;
    st_dis_n = 1'b0;
    st_show = 1'b1;
    cfg = '{label_value: 8'h1D, label_en: 8'hFF, sd_en: 1'b1, sd_match: 2'b01,
      parity_en: 1'b1, rate_hi: 1'b1};
    // A real falling edge, once every process is waiting on it, starts the reset.
    #2 resetn = 1'b0;
    repeat (20) @(posedge core_clk);
    `CHK("reset word", {32{INV}}, word_out)
    `CHK("reset word inv", {32{!INV}}, word_out_inv)
    #2 resetn = 1'b1;
    for (int i = 0; i < 100 && st_pass !== 1'b1; i++) @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    `CHK("selftest pass", 1'b1, st_pass)
    `CHK("selftest pass inv", 1'b1, st_pass_inv)
    `CHK("selftest word", `A429R_ST_PATTERN ^ {32{INV}}, word_out)
    `CHK("selftest word inv", `A429R_ST_PATTERN ^ {32{!INV}}, word_out_inv)
    `CHK("selftest update", 1'b0, update)
    $display("test selftest done");
    #2 resetn = 1'b0;
    st_dis_n = 1'b1;
    st_show = 1'b0;
    repeat (20) @(posedge core_clk);
    `CHK("mid reset word", {32{INV}}, word_out)
    `CHK("mid reset update", 1'b0, update)
    $display("test mid reset done");
    #2 resetn = 1'b1;
    repeat (60) @(posedge core_clk);
    #2;
    r = $random(seed);
    w = odd({r[20:0], 2'b01, 8'hB8});
    run("exact label", w, 32, 1'b1);
    run("srcdst miss", odd({r[20:0], 2'b10, 8'hB8}), 32, 1'b0);
    cfg.label_en = 8'h7F;
    run("masked bit", odd({r[20:0], 2'b01, 8'hB9}), 32, 1'b1);
    run("even parity", w ^ 32'h8000_0000, 32, 1'b0);
    // Parity and source/destination checks both off: a mismatching, even word loads.
    cfg.parity_en = 1'b0;
    cfg.sd_en = 1'b0;
    w = odd({r[20:0], 2'b10, 8'hB8}) ^ 32'h8000_0000;
    run("checks off", w, 32, 1'b1);
    run("short word", w, 31, 1'b0);
    cfg.parity_en = 1'b1;
    cfg.sd_en = 1'b1;
    cfg.rate_hi = 1'b0;
    r = $random(seed);
    run("low rate", odd({r[20:0], 2'b01, 8'hB8}), 32, 1'b1);
    print_verdict();
  end
endmodule

bind a429r_top a429r_assertions #(.INVERT_OUT(INVERT_OUT)) chk (.core_clk, .resetn,
  .line_input_pos, .line_input_neg, .rate_hi, .parity_enable, .selftest_word_show,
  .label_match_value, .label_compare_en, .srcdst_compare_enable, .srcdst_match_lo,
  .srcdst_match_hi, .word_out, .update);

// ===== rtl/a429r_bitrx.sv
/*
  Bit recovery from the three-level line: turns sampled high/null/low levels
  into one pulse per bit and one pulse per inter-word gap.
  Assumes all inputs are already synchronous to core_clk.
*/
`timescale 1ns/1ns
`include "a429r_defs.svh"
module a429r_bitrx
  import a429r_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Timing and line.
  input wire logic tick,
  input wire logic rate_hi,
  input wire logic line_pos,
  input wire logic line_neg,
  // Recovered bits.
  output logic bit_valid,
  output logic bit_value,
  output logic gap_seen
);

  logic [1:0] lvl;          // Present level: 10 one, 01 zero, else null.
  logic [1:0] last_lvl_r;   // Level at the previous tick.
  logic [6:0] run_r;        // Ticks of the present non-null level.
  logic [7:0] null_r;       // Ticks of null level.
  logic [6:0] minrun;       // Run length that makes a bit.
  logic [7:0] gap_len;      // Null length that closes a word.
  logic [6:0] run_nxt;      // Run count after this tick.
  logic [7:0] null_nxt;     // Null count after this tick.

  // Both lines high is treated as null, since no valid level looks like it.
  assign lvl = (line_pos ^ line_neg) ? {line_pos, line_neg} : 2'h0;
  assign minrun = rate_hi ? 7'(`A429R_HI_MINRUN) : 7'(`A429R_LO_MINRUN); // [R03]
  assign gap_len = rate_hi ? 8'(`A429R_HI_GAP) : 8'(`A429R_LO_GAP); // [R03]
  assign run_nxt = (lvl == last_lvl_r) ? ((run_r == 7'h7F) ? run_r : run_r + 7'h01)
                                       : 7'h01;
  assign null_nxt = (null_r == 8'hFF) ? null_r : null_r + 8'h01;

  // Level history and counters, advanced once per bit-timing tick.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      last_lvl_r <= 2'h0;
      run_r <= 7'h00;
      null_r <= 8'h00;
    end
    else if (tick)
    begin
      last_lvl_r <= lvl;
      if (lvl != 2'h0)
      begin
        run_r <= run_nxt;
        null_r <= 8'h00;
      end
      else
      begin
        run_r <= 7'h00;
        null_r <= null_nxt;
      end
    end
  end

  // One bit per run, emitted once the run is long enough to be trusted.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bit_valid <= 1'b0;
      bit_value <= 1'b0;
      gap_seen <= 1'b0;
    end
    else
    begin
      bit_valid <= tick && (lvl != 2'h0) && (run_nxt == minrun); // [R15]
      bit_value <= lvl[1];
      gap_seen <= tick && (lvl == 2'h0) && (null_nxt == gap_len); // [R15]
    end
  end

endmodule

// ===== rtl/a429r_defs.svh
/*
  Constants of the label-filtering word receiver: bit timing, framing
  thresholds, reset values and the self-test word.
  Assumes a bit-timing clock of nominally 1 MHz sampled by the core clock.
*/
`ifndef A429R_DEFS_SVH
`define A429R_DEFS_SVH

// Nominal bit-timing clock rate in hertz.
`define A429R_BITCLK_HZ 1000000
// Line rates in bit per second for high and low speed.
`define A429R_HI_BPS 100000
`define A429R_LO_BPS 12500
// Bit-timing ticks in one bit cell.
`define A429R_HI_TPB (`A429R_BITCLK_HZ / `A429R_HI_BPS)
`define A429R_LO_TPB (`A429R_BITCLK_HZ / `A429R_LO_BPS)
// Ticks of steady level that make a bit: three tenths of a cell.
`define A429R_HI_MINRUN ((`A429R_HI_TPB * 3) / 10)
`define A429R_LO_MINRUN ((`A429R_LO_TPB * 3) / 10)
// Ticks of null level that close a word: one and a half cells.
`define A429R_HI_GAP ((`A429R_HI_TPB * 3) / 2)
`define A429R_LO_GAP ((`A429R_LO_TPB * 3) / 2)
// Bits in one word.
`define A429R_WORD_BITS 32
// Output latch value under reset.
`define A429R_WORD_RST 32'h0000_0000
// Self-test word; it carries odd parity.
`define A429R_ST_PATTERN 32'hA5A5_5A5B
// Settling count at which the self-test starts, four core cycles after reset.
`define A429R_ST_SETTLE 2'h3

`endif

// ===== rtl/a429r_pkg.sv
/*
  Types shared by the word receiver: the configuration bundle and the
  self-test sequencer states.
  Assumes the constants header is compiled alongside.
*/
package a429r_pkg;

  // Configuration pins after synchronisation.
  typedef struct packed {
    logic [7:0] label_value; // Label match value, bit 7 against line bit 1.
    logic [7:0] label_en;    // Per-bit compare enables, same order.
    logic       sd_en;       // Source/destination compare enable.
    logic [1:0] sd_match;    // Bit 1 against line bit 10, bit 0 against bit 9.
    logic       parity_en;   // Odd-parity check enable.
    logic       rate_hi;     // High-speed line rate.
  } a429r_cfg_s;

  // Self-test sequencer states.
  typedef enum logic [2:0] {
    ST_SETTLE,
    ST_FEED,
    ST_CLOSE,
    ST_WAIT,
    ST_OFF
  } a429r_st_e;

endpackage

// ===== rtl/a429r_top.sv
/*
  Autonomous label-filtering word receiver: synchronises the pins, frames
  32-bit words, qualifies them by label, source/destination and parity,
  and holds the last accepted word on 32 parallel outputs.
  Assumes the line levels come from an external line receiver as two
  logic signals and that the bit-timing clock is a free-running pin.
*/
`timescale 1ns/1ns
`include "a429r_defs.svh"

// How it works
// [R01] Reset clears latch and all receiver state.
// [R02] System supplies 1 MHz bit clock, one percent.
// [R03] Rate pin selects 100 or 12.5 kbit/s.
// [R04] Parity enabled: drop words with even parity.
// [R05] Parity disabled: keep all 32 bits.
// [R06] Self-test low: run self-test after reset.
// [R07] Show high: self-test word drives outputs.
// [R08] Label value compared bit-reversed to bits 1-8.
// [R09] Compare enables mask individual label bits.
// [R10] Source/destination enable checks bits 9, 10.
// [R11] Update rises per new word, holds high.
// [R12] Outputs carry last word, change with update.
// [R13] Inverted variant drives complemented outputs.
// [R14] Accept only when every enabled check passes.
// [R15] Frame exactly 32 bits between gaps.
module a429r_top
  import a429r_pkg::*;
#(
  parameter bit INVERT_OUT = 1'b0
)
(
  // Clock and master reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Bit timing and line.
  input wire logic bit_timing_clock,
  input wire logic line_input_pos,
  input wire logic line_input_neg,
  // Mode pins.
  input wire logic rate_hi,
  input wire logic parity_enable,
  input wire logic selftest_disable_n,
  input wire logic selftest_word_show,
  // Label and source/destination filter pins.
  input wire logic [7:0] label_match_value,
  input wire logic [7:0] label_compare_en,
  input wire logic srcdst_compare_enable,
  input wire logic srcdst_match_lo,
  input wire logic srcdst_match_hi,
  // Word outputs and status.
  output logic [31:0] word_out,
  output logic update,
  output logic selftest_pass
);

  // Qualification of a framed word against the configuration.
  function automatic logic a429r_accept(input logic [31:0] w, input a429r_cfg_s c);
    logic lab_ok;
    logic sd_ok;
    logic par_ok;
    lab_ok = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      // Value bit i meets line bit 8-i, held at word index 7-i.
      if (c.label_en[i] && (w[7 - i] != c.label_value[i])) // [R08] [R09]
        lab_ok = 1'b0;
    end
    sd_ok = !c.sd_en || ({w[9], w[8]} == c.sd_match); // [R10]
    par_ok = !c.parity_en || (^w); // [R04] [R05]
    return lab_ok && sd_ok && par_ok; // [R14]
  endfunction

  // Pin synchronisers: first stage, second stage.
  a429r_cfg_s cfg_meta_r;    // First stage of the configuration pins.
  a429r_cfg_s cfg_r;         // Synchronised configuration.
  logic [4:0] pin_meta_r;    // First stage of clock, line and test pins.
  logic [4:0] pin_r;         // Synchronised clock, line and test pins.
  logic bitclk_old_r;        // Previous synchronised bit clock, for edges.
  logic tick;                // One core cycle per bit-clock rising edge.

  // Bit recovery.
  logic rx_bit_valid;        // A bit came off the line.
  logic rx_bit_value;        // Its value.
  logic rx_gap;              // The line went idle long enough to end a word.

  // Word assembly.
  logic [31:0] asm_r;        // Word being assembled, index 0 is line bit 1.
  logic [5:0] cnt_r;         // Bits gathered so far.
  logic ovf_r;               // More than a word's worth of bits seen.
  logic feed_valid;          // Bit into the assembler from either source.
  logic feed_value;          // Its value.
  logic feed_close;          // Word end into the assembler.
  logic frame_done_r;        // A complete 32-bit frame is in frame_r.
  logic [31:0] frame_r;      // Last complete frame.

  // Self-test sequencer.
  a429r_st_e st_r;           // Sequencer state.
  logic [1:0] settle_r;      // Settling count after reset.
  logic [4:0] st_idx_r;      // Index of the self-test bit being fed.
  logic [31:0] st_pattern;   // Self-test word.

  // Output stage.
  logic load_pend_r;         // Accepted word waits for the update edge.
  logic [31:0] hold_r;       // Accepted word awaiting the latch.
  logic show_pend_r;         // Self-test word waits for the outputs.

  assign st_pattern = `A429R_ST_PATTERN;

  // Two flip-flops on every pin except resetn before any logic reads it.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_meta_r <= '0;
      cfg_r <= '0;
      pin_meta_r <= 5'h00;
      pin_r <= 5'h00;
    end
    else
    begin
      cfg_meta_r <= '{label_value: label_match_value, label_en: label_compare_en,
                      sd_en: srcdst_compare_enable,
                      sd_match: {srcdst_match_hi, srcdst_match_lo},
                      parity_en: parity_enable, rate_hi: rate_hi};
      cfg_r <= cfg_meta_r;
      pin_meta_r <= {selftest_word_show, selftest_disable_n, line_input_neg,
                     line_input_pos, bit_timing_clock};
      pin_r <= pin_meta_r;
    end
  end

  // Rising edges of the synchronised bit-timing clock pace the line sampler.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      bitclk_old_r <= 1'b0;
    else
      bitclk_old_r <= pin_r[0];
  end

  assign tick = pin_r[0] && !bitclk_old_r; // [R02]

  // Line sampler; bit timing follows the rate pin.
  a429r_bitrx u_bitrx (
    .core_clk(core_clk),
    .resetn(resetn),
    .tick(tick),
    .rate_hi(cfg_r.rate_hi),
    .line_pos(pin_r[1]),
    .line_neg(pin_r[2]),
    .bit_valid(rx_bit_valid),
    .bit_value(rx_bit_value),
    .gap_seen(rx_gap)
  );

  // The self-test owns the assembler while it runs; the line is ignored.
  always_comb
  begin
    if (st_r == ST_OFF)
    begin
      feed_valid = rx_bit_valid;
      feed_value = rx_bit_value;
      feed_close = rx_gap;
    end
    else
    begin
      feed_valid = (st_r == ST_FEED);
      feed_value = st_pattern[st_idx_r];
      feed_close = (st_r == ST_CLOSE);
    end
  end

  // Frame assembly: bit 1 arrives first, a gap closes the word.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      asm_r <= 32'h0000_0000;
      cnt_r <= 6'h00;
      ovf_r <= 1'b0;
      frame_done_r <= 1'b0;
      frame_r <= 32'h0000_0000;
    end
    else
    begin
      frame_done_r <= 1'b0;
      if (feed_close)
      begin
        // Only an exact word of bits counts; short or long frames are dropped.
        if ((cnt_r == 6'(`A429R_WORD_BITS)) && !ovf_r) // [R15]
        begin
          frame_done_r <= 1'b1;
          frame_r <= asm_r;
        end
        cnt_r <= 6'h00;
        ovf_r <= 1'b0;
      end
      else if (feed_valid)
      begin
        if (cnt_r < 6'(`A429R_WORD_BITS))
        begin
          asm_r[cnt_r[4:0]] <= feed_value; // [R15]
          cnt_r <= cnt_r + 6'h01;
        end
        else
          ovf_r <= 1'b1; // [R15]
      end
    end
  end

  // Self-test: feeds its word through the assembler after reset, if enabled.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= ST_SETTLE;
      settle_r <= 2'h0;
      st_idx_r <= 5'h00;
      selftest_pass <= 1'b0;
      show_pend_r <= 1'b0;
    end
    else
    begin
      show_pend_r <= 1'b0;
      case (st_r)
        ST_SETTLE:
        begin
          // Wait for the test pins to pass the synchroniser.
          settle_r <= settle_r + 2'h1;
          if (settle_r == `A429R_ST_SETTLE)
            st_r <= pin_r[3] ? ST_OFF : ST_FEED; // [R06]
        end
        ST_FEED:
        begin
          st_idx_r <= st_idx_r + 5'h01;
          if (st_idx_r == 5'h1F)
            st_r <= ST_CLOSE;
        end
        ST_CLOSE:
          st_r <= ST_WAIT;
        ST_WAIT:
        begin
          // The frame must reproduce the test word and carry odd parity.
          selftest_pass <= frame_done_r && (frame_r == st_pattern) && (^frame_r);
          show_pend_r <= pin_r[4] && frame_done_r; // [R07]
          st_r <= ST_OFF;
        end
        ST_OFF:
          st_r <= ST_OFF;
        default:
          st_r <= ST_OFF;
      endcase
    end
  end

  // Accepted words first drop update for a cycle, then load with its rise.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      load_pend_r <= 1'b0;
      hold_r <= `A429R_WORD_RST;
    end
    else
    begin
      load_pend_r <= 1'b0;
      if (frame_done_r && (st_r == ST_OFF) && a429r_accept(frame_r, cfg_r)) // [R14]
      begin
        load_pend_r <= 1'b1;
        hold_r <= frame_r;
      end
    end
  end

  // New-word flag: low for the cycle before a load, high from the load on.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      update <= 1'b0; // [R01]
    else if (frame_done_r && (st_r == ST_OFF) && a429r_accept(frame_r, cfg_r))
      update <= 1'b0; // [R11]
    else if (load_pend_r)
      update <= 1'b1; // [R11]
  end

  // Output latch, true or complemented as the variant requires.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      word_out <= INVERT_OUT ? ~`A429R_WORD_RST : `A429R_WORD_RST; // [R01] [R13]
    else if (load_pend_r)
      word_out <= INVERT_OUT ? ~hold_r : hold_r; // [R12] [R13]
    else if (show_pend_r)
      word_out <= INVERT_OUT ? ~frame_r : frame_r; // [R07] [R13]
  end

endmodule
